// ===== rtl/sfc_pkg.sv
// Shared constants and types for the serial flash command interpreter.
// Assumes a 50 MHz system clock; link timing comes from the host's serial clock.
package sfc_pkg;

   localparam int SYS_CLK_MHZ = 50;

   // Instruction codes
   localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_ENTER_OTP     = 8'h3A;
   localparam logic [7:0] OP_UNIQUE_ID     = 8'h4B;
   localparam logic [7:0] OP_FULL_ERASE_A  = 8'h60;
   localparam logic [7:0] OP_MFR_DEV_ID    = 8'h90;
   localparam logic [7:0] OP_JEDEC_ID      = 8'h9F;
   localparam logic [7:0] OP_RELEASE_ID    = 8'hAB;
   localparam logic [7:0] OP_POWER_DOWN    = 8'hB9;
   localparam logic [7:0] OP_FULL_ERASE_B  = 8'hC7;

   // Bit counts seen in a frame
   localparam logic [5:0] BITS_OPCODE      = 6'd8;
   localparam logic [5:0] BITS_WRITE_STAT  = 6'd16;
   localparam logic [5:0] BITS_ADDR_LAST   = 6'd31;
   localparam logic [5:0] BITS_HDR_ID      = 6'd32;
   localparam logic [5:0] BITS_HDR_UID     = 6'd40;
   localparam logic [5:0] BITS_NO_REPLY    = 6'd63;
   localparam logic [5:0] JEDEC_BITS       = 6'd24;

   // Status byte layout
   localparam int ST_BUSY  = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_PROT  = 2;
   localparam int ST_SPB   = 7;

   localparam logic [2:0] BP_NONE     = 3'b000;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // Times as printed or chosen, then cycle counts
   localparam int PD_ENTRY_NS    = 3000;
   localparam int RES_SHORT_NS   = 3000;
   localparam int RES_LONG_NS    = 5000;
   localparam int PUW_MS         = 1;
   localparam int FULL_ERASE_MS  = 100;
   localparam int PD_ENTRY_CYC   = (PD_ENTRY_NS * SYS_CLK_MHZ) / 1000;
   localparam int RES_SHORT_CYC  = (RES_SHORT_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int RES_LONG_CYC   = (RES_LONG_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int PUW_CYC        = PUW_MS * 1000 * SYS_CLK_MHZ;
   localparam int FULL_ERASE_CYC = FULL_ERASE_MS * 1000 * SYS_CLK_MHZ;

   typedef enum logic [1:0] {
      PWR_NORMAL,
      PWR_ENTERING,
      PWR_DOWN,
      PWR_RELEASING
   } sfc_pwr_t;

   // System state seen by the link side
   typedef struct packed {
      logic       busy;
      logic       down;
      logic       transit;
      logic [7:0] status;
   } sfc_to_link_t;

   // Frame record held by the link side after select rises
   typedef struct packed {
      logic [7:0] opcode;
      logic [5:0] count;
   } sfc_frame_t;

endpackage

// ===== rtl/sfc_flash_cmd.sv
// Serial flash instruction handling: erase, power-down, ID reads, OTP mode.
// Assumes block_protect_bits, status_protect_bit and otp_lock_stored are on clk_sys;
// select_n must stay high at least three clk_sys periods between frames.
//
// What this block does
// - Full erase with latch set erases array
// - Erase only if select rises after bit eight
// - Erase busy sets progress; end clears latch
// - Refuse full erase when any protection set
// - Power-down opcode enters power-down state
// - Power-down accepts only the release opcode
// - Always power up in normal operation
// - Short release waits before accepting instructions
// - Release opcode with dummies streams device ID
// - ID-form release waits the long interval
// - Release opcode ignored while write busy
// - Manufacturer/device pair, order set by address
// - Unique ID after four dummy bytes
// - Standard ID gives three bytes
// - Secure mode maps security sector
// - Secure status shows lock; lock blocks writes
// - Secure write-status programs the lock bit
// - Security sector writable only unlocked, unprotected
// - Other sectors writable in secure if unlocked
// - Write-disable leaves secure mode
// - Secure mode erases only by sector erase
// - Writes rejected until power-up delay ends
`timescale 1ns/100ps
`default_nettype none

module sfc_flash_cmd #(
   parameter logic [7:0]  MANUFACTURER_ID = 8'h5A,              // Arbitrary value
   parameter logic [7:0]  DEVICE_ID       = 8'h12,              // Arbitrary value
   parameter logic [7:0]  MEMORY_TYPE     = 8'h40,              // Arbitrary value
   parameter logic [7:0]  CAPACITY_ID     = 8'h10,              // Arbitrary value
   parameter logic [63:0] UNIQUE_ID       = 64'h0123_4567_89AB_CDEF, // Arbitrary value
   parameter int          PU_WRITE_CYC    = sfc_pkg::PUW_CYC,
   parameter int          ERASE_CYC       = sfc_pkg::FULL_ERASE_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       spi_clk,
   input  wire logic       select_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   output logic            spi_miso_oe_n,
   input  wire logic [2:0] block_protect_bits,
   input  wire logic       status_protect_bit,
   input  wire logic       otp_lock_stored,
   output logic            write_in_progress,
   output logic            write_enable_latch,
   output logic            power_down,
   output logic            otp_mode,
   output logic            otp_lock_bit,
   output logic            writes_ready,
   output logic            array_erase_all,
   output logic [7:0]      array_erase_value,
   output logic            otp_lock_program,
   output logic            security_sector_mapped,
   output logic            security_sector_write_ok,
   output logic            array_write_ok,
   output logic            sector_erase_only
);

   // System domain
   logic                 rst_s1;
   logic                 rst_sync_n;
   logic                 sel_s1;
   logic                 sel_s2;
   logic                 sel_s3;
   logic                 tog_s1;
   logic                 tog_s2;
   logic                 tog_seen;
   logic                 lock_loaded;
   sfc_pkg::sfc_pwr_t    pwr;
   logic [31:0]          pwr_tmr;
   logic [31:0]          pwr_lim;
   logic [31:0]          ers_tmr;
   logic [31:0]          pu_cnt;
   logic [7:0]           status;
   sfc_pkg::sfc_to_link_t to_link;

   // Link domain
   logic                 active;
   logic                 frame_tog;
   sfc_pkg::sfc_frame_t  fr;
   logic                 addr_lsb;
   logic [5:0]           dcnt;
   sfc_pkg::sfc_to_link_t lk_s1;
   sfc_pkg::sfc_to_link_t lk_s2;

   // Bits that precede the reply; opcodes without a reply get 63, which the reply logic excludes
   function automatic logic [5:0] hdr_bits(input logic [7:0] op);
      case (op)
         sfc_pkg::OP_READ_STATUS,
         sfc_pkg::OP_JEDEC_ID:   hdr_bits = sfc_pkg::BITS_OPCODE;
         sfc_pkg::OP_RELEASE_ID,
         sfc_pkg::OP_MFR_DEV_ID: hdr_bits = sfc_pkg::BITS_HDR_ID;
         sfc_pkg::OP_UNIQUE_ID:  hdr_bits = sfc_pkg::BITS_HDR_UID;
         default:                hdr_bits = sfc_pkg::BITS_NO_REPLY;
      endcase
   endfunction

   function automatic logic reply_bit(input logic [7:0] op,
                                      input logic [5:0] d,
                                      input logic       lsb,
                                      input logic [7:0] st);
      logic [15:0] pair;
      logic [23:0] jedec;
      pair  = lsb ? {DEVICE_ID, MANUFACTURER_ID} : {MANUFACTURER_ID, DEVICE_ID};
      jedec = {MANUFACTURER_ID, MEMORY_TYPE, CAPACITY_ID};
      case (op)
         sfc_pkg::OP_READ_STATUS: reply_bit = st[3'd7 - d[2:0]];
         sfc_pkg::OP_JEDEC_ID:
            reply_bit = (d < sfc_pkg::JEDEC_BITS) ? jedec[5'd23 - d[4:0]] : 1'b0;
         sfc_pkg::OP_RELEASE_ID:  reply_bit = DEVICE_ID[3'd7 - d[2:0]];
         sfc_pkg::OP_MFR_DEV_ID:  reply_bit = pair[4'd15 - d[3:0]];
         sfc_pkg::OP_UNIQUE_ID:   reply_bit = UNIQUE_ID[6'd63 - d];
         default:                 reply_bit = 1'b0;
      endcase
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1     <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1     <= 1'b1;
         rst_sync_n <= rst_s1;
      end
   end

   // Frame end: select and frame toggle cross by two flops each
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sel_s1   <= 1'b1;
         sel_s2   <= 1'b1;
         sel_s3   <= 1'b1;
         tog_s1   <= 1'b0;
         tog_s2   <= 1'b0;
         tog_seen <= 1'b0;
      end else begin
         sel_s1 <= select_n;
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
         tog_s1 <= frame_tog;
         tog_s2 <= tog_s1;
         if (sel_s2 && !sel_s3) begin
            tog_seen <= tog_s2;
         end
      end
   end

   // The frame record is static once select is high, so it is read directly here
   logic take;
   logic is8;
   logic normal;
   logic pu_done;
   logic erase_op;
   logic erase_done;
   logic cmd_wren;
   logic cmd_wdis;
   logic cmd_pd;
   logic cmd_otp;
   logic cmd_erase;
   logic cmd_lock;
   logic cmd_rel_short;
   logic cmd_rel_long;

   assign take     = sel_s2 && !sel_s3 && (tog_s2 != tog_seen);
   assign is8      = (fr.count == sfc_pkg::BITS_OPCODE);
   assign normal   = take && (pwr == sfc_pkg::PWR_NORMAL) && !write_in_progress;
   assign pu_done  = (pu_cnt == 32'(PU_WRITE_CYC));
   assign erase_op = (fr.opcode == sfc_pkg::OP_FULL_ERASE_A) || (fr.opcode == sfc_pkg::OP_FULL_ERASE_B);

   assign cmd_wren = normal && is8 && pu_done && (fr.opcode == sfc_pkg::OP_WRITE_ENABLE);
   assign cmd_wdis = normal && is8 && (fr.opcode == sfc_pkg::OP_WRITE_DISABLE);
   assign cmd_pd   = normal && is8 && (fr.opcode == sfc_pkg::OP_POWER_DOWN);
   assign cmd_otp  = normal && is8 && (fr.opcode == sfc_pkg::OP_ENTER_OTP);
   assign cmd_erase = normal && is8 && erase_op && write_enable_latch && pu_done
                      && (block_protect_bits == sfc_pkg::BP_NONE)
                      && !otp_mode;
   assign cmd_lock = normal && otp_mode && write_enable_latch && pu_done
                     && (fr.opcode == sfc_pkg::OP_WRITE_STATUS)
                     && (fr.count == sfc_pkg::BITS_WRITE_STAT);
   // Only the release opcode is heard while down
   assign cmd_rel_short = take && (pwr == sfc_pkg::PWR_DOWN)
                          && (fr.opcode == sfc_pkg::OP_RELEASE_ID) && is8;
   assign cmd_rel_long  = take && (pwr == sfc_pkg::PWR_DOWN)
                          && (fr.opcode == sfc_pkg::OP_RELEASE_ID)
                          && (fr.count == sfc_pkg::BITS_HDR_ID);
   assign erase_done = write_in_progress && (ers_tmr == 32'(ERASE_CYC - 1));

   // Power state; reset stands for power-up and always lands in normal operation
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwr     <= sfc_pkg::PWR_NORMAL;
         pwr_tmr <= 32'h0000_0000;
         pwr_lim <= 32'h0000_0000;
      end else begin
         case (pwr)
            sfc_pkg::PWR_NORMAL: begin
               if (cmd_pd) begin
                  pwr     <= sfc_pkg::PWR_ENTERING;
                  pwr_tmr <= 32'h0000_0000;
                  pwr_lim <= 32'(sfc_pkg::PD_ENTRY_CYC - 1);
               end
            end
            sfc_pkg::PWR_DOWN: begin
               if (cmd_rel_short) begin
                  pwr     <= sfc_pkg::PWR_RELEASING;
                  pwr_tmr <= 32'h0000_0000;
                  pwr_lim <= 32'(sfc_pkg::RES_SHORT_CYC - 1);
               end else if (cmd_rel_long) begin
                  pwr     <= sfc_pkg::PWR_RELEASING;
                  pwr_tmr <= 32'h0000_0000;
                  pwr_lim <= 32'(sfc_pkg::RES_LONG_CYC - 1);
               end
            end
            sfc_pkg::PWR_ENTERING,
            sfc_pkg::PWR_RELEASING: begin
               // Frames arriving during either wait are dropped
               if (pwr_tmr == pwr_lim) begin
                  pwr <= (pwr == sfc_pkg::PWR_ENTERING) ? sfc_pkg::PWR_DOWN : sfc_pkg::PWR_NORMAL;
               end else begin
                  pwr_tmr <= pwr_tmr + 32'h0000_0001;
               end
            end
            default: pwr <= sfc_pkg::PWR_NORMAL;
         endcase
      end
   end

   // Self-timed full erase
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         write_in_progress <= 1'b0;
         ers_tmr           <= 32'h0000_0000;
      end else if (cmd_erase) begin
         write_in_progress <= 1'b1;
         ers_tmr           <= 32'h0000_0000;
      end else if (erase_done) begin
         write_in_progress <= 1'b0;
      end else if (write_in_progress) begin
         ers_tmr <= ers_tmr + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         write_enable_latch <= 1'b0;
      end else if (cmd_wren) begin
         write_enable_latch <= 1'b1;
      end else if (cmd_wdis || erase_done || cmd_lock) begin
         write_enable_latch <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         otp_mode <= 1'b0;
      end else if (cmd_otp) begin
         otp_mode <= 1'b1;
      end else if (cmd_wdis) begin
         otp_mode <= 1'b0;
      end
   end

   // Lock bit is nonvolatile: its stored level is taken once after reset release
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lock_loaded  <= 1'b0;
         otp_lock_bit <= 1'b0;
      end else if (!lock_loaded) begin
         lock_loaded  <= 1'b1;
         otp_lock_bit <= otp_lock_stored;
      end else if (cmd_lock) begin
         otp_lock_bit <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pu_cnt <= 32'h0000_0000;
      end else if (!pu_done) begin
         pu_cnt <= pu_cnt + 32'h0000_0001;
      end
   end

   // Registered outputs and the status byte handed to the link side
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         array_erase_all          <= 1'b0;
         array_erase_value        <= sfc_pkg::ERASED_BYTE;
         otp_lock_program         <= 1'b0;
         power_down               <= 1'b0;
         writes_ready             <= 1'b0;
         security_sector_mapped   <= 1'b0;
         security_sector_write_ok <= 1'b0;
         array_write_ok           <= 1'b0;
         sector_erase_only        <= 1'b0;
         status                   <= 8'h00;
         to_link                  <= '0;
      end else begin
         array_erase_all          <= cmd_erase;
         array_erase_value        <= sfc_pkg::ERASED_BYTE;
         otp_lock_program         <= cmd_lock;
         power_down               <= (pwr == sfc_pkg::PWR_DOWN);
         writes_ready             <= pu_done;
         security_sector_mapped   <= otp_mode;
         security_sector_write_ok <= otp_mode && !otp_lock_bit && pu_done
                                     && (block_protect_bits == sfc_pkg::BP_NONE);
         array_write_ok           <= pu_done && !(otp_mode && otp_lock_bit);
         sector_erase_only        <= otp_mode;
         status                   <= 8'h00;
         status[sfc_pkg::ST_BUSY]  <= write_in_progress;
         status[sfc_pkg::ST_LATCH] <= write_enable_latch;
         status[sfc_pkg::ST_PROT +: 3] <= block_protect_bits;
         status[sfc_pkg::ST_SPB]  <= otp_mode ? otp_lock_bit : status_protect_bit;
         to_link.busy             <= write_in_progress;
         to_link.down             <= (pwr == sfc_pkg::PWR_DOWN);
         to_link.transit          <= (pwr == sfc_pkg::PWR_ENTERING) || (pwr == sfc_pkg::PWR_RELEASING);
         to_link.status           <= status;
      end
   end

   // Link side: active drops asynchronously whenever select is high
   always_ff @(posedge spi_clk or posedge select_n) begin
      if (select_n) begin
         active <= 1'b0;
      end else begin
         active <= 1'b1;
      end
   end

   // Slow system state enters the link clock through two flops; the opcode
   // phase gives eight edges before any reply bit depends on it
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_s1 <= '0;
         lk_s2 <= '0;
      end else begin
         lk_s1 <= to_link;
         lk_s2 <= lk_s1;
      end
   end

   // Shift-in on rising edges; the record holds after select rises
   always_ff @(posedge spi_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_tog <= 1'b0;
         fr        <= '0;
         addr_lsb  <= 1'b0;
         dcnt      <= 6'd0;
      end else if (!active) begin
         frame_tog <= ~frame_tog;
         fr.opcode <= {7'd0, spi_mosi};
         fr.count  <= 6'd1;
         dcnt      <= 6'd0;
      end else begin
         if (fr.count < sfc_pkg::BITS_OPCODE) begin
            fr.opcode <= {fr.opcode[6:0], spi_mosi};
         end
         if (fr.count == sfc_pkg::BITS_ADDR_LAST) begin
            addr_lsb <= spi_mosi;
         end
         if (fr.count < sfc_pkg::BITS_OPCODE || fr.count < hdr_bits(fr.opcode)) begin
            fr.count <= fr.count + 6'd1;
         end else if (fr.count == hdr_bits(fr.opcode)) begin
            dcnt <= dcnt + 6'd1;
         end
      end
   end

   // Reply on falling edges; the release opcode answers only when not busy
   logic reply_ok;
   assign reply_ok = !lk_s2.transit &&
                     ((fr.opcode == sfc_pkg::OP_RELEASE_ID) ? !lk_s2.busy
                      : (!lk_s2.down
                         && (fr.opcode == sfc_pkg::OP_READ_STATUS || !lk_s2.busy)));

   always_ff @(negedge spi_clk or posedge select_n) begin
      if (select_n) begin
         spi_miso      <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else if (fr.count == hdr_bits(fr.opcode) && fr.count != sfc_pkg::BITS_NO_REPLY
                   && reply_ok) begin
         spi_miso      <= reply_bit(fr.opcode, dcnt, addr_lsb, lk_s2.status);
         spi_miso_oe_n <= 1'b0;
      end else begin
         spi_miso      <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end
   end

endmodule // sfc_flash_cmd

`default_nettype wire

// ===== tb/sfc_flash_cmd_monitor.sv
// Concurrent checks on the flash command block's top-level ports.
// Assumes a single clk_sys domain; bound to every instance below.
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_cmd_monitor (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       select_n,
   input wire logic       spi_miso_oe_n,
   input wire logic [2:0] block_protect_bits,
   input wire logic       write_in_progress,
   input wire logic       write_enable_latch,
   input wire logic       power_down,
   input wire logic       otp_mode,
   input wire logic       otp_lock_bit,
   input wire logic       writes_ready,
   input wire logic       array_erase_all,
   input wire logic [7:0] array_erase_value,
   input wire logic       otp_lock_program,
   input wire logic       security_sector_mapped,
   input wire logic       security_sector_write_ok,
   input wire logic       array_write_ok,
   input wire logic       sector_erase_only
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_erase_busy;
      write_in_progress[*8];
   endsequence
   sequence s_fresh;
      (!power_down && !writes_ready)[*8];
   endsequence
   a_erase_needs_latch: assert property (array_erase_all |-> write_enable_latch && write_in_progress)
      else $error("erase started without latch or busy flag");
   a_erase_one_pulse: assert property (array_erase_all |=> !array_erase_all ##1 write_in_progress)
      else $error("erase start is not a single pulse");
   a_erase_all_ones: assert property (array_erase_value == 8'hFF)
      else $error("erase value is not all ones");
   a_erase_unprotected: assert property (array_erase_all |-> block_protect_bits == 3'b000 && !otp_mode)
      else $error("full erase while protected or in secure mode");
   a_erase_busy_held: assert property ($rose(write_in_progress) |-> s_erase_busy)
      else $error("busy flag dropped early");
   a_erase_end_latch: assert property ($fell(write_in_progress) |-> !write_enable_latch)
      else $error("latch still set after erase");
   a_power_up_state: assert property ($rose(rst_n) |-> s_fresh)
      else $error("power-up not normal or writes allowed early");
   // The mapping outputs are registered, so they trail the mode flag by one cycle
   a_otp_map_follow: assert property (security_sector_mapped == $past(otp_mode)
      && sector_erase_only == $past(otp_mode))
      else $error("sector mapping does not follow secure mode");
   a_lock_stays_set: assert property (otp_lock_bit |=> otp_lock_bit)
      else $error("lock bit cleared");
   a_lock_blocks_write: assert property (otp_lock_bit && $past(otp_lock_bit) && otp_mode && $past(otp_mode)
      |-> !security_sector_write_ok && !array_write_ok)
      else $error("writes allowed while locked");
   a_lock_prog_secure: assert property (otp_lock_program |-> otp_mode)
      else $error("lock programmed outside secure mode");
   a_idle_out_off: assert property (select_n && $past(select_n) |-> spi_miso_oe_n)
      else $error("output driven while deselected");
endmodule // sfc_flash_cmd_monitor
bind sfc_flash_cmd sfc_flash_cmd_monitor sfc_flash_cmd_monitor_inst (.*);
`default_nettype wire

// ===== tb/sfc_host_model.sv
// Behavioural host controller: sends one frame per call, MSB first.
// Assumes the caller spaces frames; serial clock stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module sfc_host_model (
   output logic      spi_clk,
   output logic      select_n,
   output logic      spi_mosi,
   input wire logic  spi_miso,
   input wire logic  spi_miso_oe_n
);
   initial begin
      spi_clk = 1'b0;
      select_n = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic xfer(input logic [127:0] tx, input int n, output logic [127:0] rx);
      rx = '0;
      select_n = 1'b0;
      #33;
      for (int i = n - 1; i >= 0; i--) begin
         spi_mosi = tx[i];
         #40;
         spi_clk = 1'b1;
         rx = {rx[126:0], spi_miso_oe_n ? 1'b1 : spi_miso};
         #40;
         spi_clk = 1'b0;
      end
      #20;
      select_n = 1'b1; // Rise right after the last counted bit
      spi_mosi = ~spi_mosi;
      #300;
   endtask
endmodule // sfc_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench: ID reads, full erase, power-down and secure mode.
// Assumes the host model drives the link; long counts are shortened.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [7:0]  MFR = 8'h3C; // Arbitrary value
   localparam logic [7:0]  DEV = 8'h21; // Arbitrary value
   localparam logic [7:0]  MEM = 8'h40; // Arbitrary value
   localparam logic [7:0]  CAP = 8'h10; // Arbitrary value
   localparam logic [63:0] UID = 64'h1122_3344_5566_7788; // Arbitrary value
   logic clk_sys, rst_n, spi_clk, select_n, spi_mosi, spi_miso, spi_miso_oe_n;
   logic status_protect_bit, otp_lock_stored, write_in_progress, write_enable_latch, power_down;
   logic otp_mode, otp_lock_bit, writes_ready, array_erase_all, otp_lock_program;
   logic security_sector_mapped, security_sector_write_ok, array_write_ok, sector_erase_only;
   logic [2:0]   block_protect_bits;
   logic [7:0]   array_erase_value;
   logic [127:0] rx;
   logic [31:0]  seed = 32'h5c3b_d6be;
   int           num_errors = 0;
   int           check_count = 0;
   sfc_flash_cmd #(.MANUFACTURER_ID(MFR), .DEVICE_ID(DEV), .MEMORY_TYPE(MEM), .CAPACITY_ID(CAP),
      .UNIQUE_ID(UID), .PU_WRITE_CYC(20), .ERASE_CYC(500)) sfc_flash_cmd_inst (.*);
   sfc_host_model sfc_host_model_inst (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Each frame ends on a falling edge so later input changes stay off the sampling edge
   task automatic sx(input logic [127:0] tx, input int n);
      sfc_host_model_inst.xfer(tx, n, rx);
      @(negedge clk_sys);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 800; i++) begin
         @(negedge clk_sys);
         if (write_in_progress === 1'b0) return;
      end
      num_errors++;
      stop_test();
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #1_000_000;
      num_errors++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      block_protect_bits = 3'b000;
      status_protect_bit = 1'b1;
      otp_lock_stored = 1'b0;
      cyc(20);
      rst_n = 1'b1;
      cyc(2);
      chk({power_down, writes_ready}, 2'b00);
      cyc(30);
      chk(writes_ready, 1'b1);
      sx({8'h9F, 24'h0}, 32);
      chk(rx[23:0], {MFR, MEM, CAP});
      sx({8'hAB, 40'h0}, 48);
      chk(rx[15:0], {DEV, DEV});
      for (int a = 0; a < 2; a++) begin
         sx({8'h90, 23'h0, a[0], 32'h0}, 64);
         chk(rx[31:0], a[0] ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV});
      end
      sx({8'h4B, 96'h0}, 104);
      chk(rx[63:0], UID);
      seed = lfsr(seed);
      block_protect_bits = seed[2:0] | 3'b001;
      sx(8'h06, 8);
      sx(8'hC7, 8);
      chk(write_in_progress, 1'b0);
      block_protect_bits = 3'b000;
      sx(9'h18E, 9);
      chk(write_in_progress, 1'b0);
      for (int k = 0; k < 2; k++) begin
         sx(8'h06, 8);
         sx(k ? 8'h60 : 8'hC7, 8);
         chk(write_in_progress, 1'b1);
         sx(16'h0500, 16);
         chk(rx[7:0], 8'h83);
         sx({8'hAB, 32'h0}, 40);
         chk(rx[7:0], 8'hFF);
         wait_idle();
         chk(write_enable_latch, 1'b0);
      end
      sx(8'hB9, 8);
      cyc(160);
      chk(power_down, 1'b1);
      sx(16'h0500, 16);
      chk(rx[7:0], 8'hFF);
      sx(8'hAB, 8);
      cyc(160); // Select stays high through the short release wait
      sx(16'h0500, 16);
      chk(rx[7:0], 8'h80);
      sx(8'hB9, 8);
      cyc(160);
      sx({8'hAB, 32'h0}, 40);
      cyc(260); // Longer wait for the identifying release
      sx(16'h0500, 16);
      chk(rx[7:0], 8'h80);
      sx(8'h3A, 8);
      chk({otp_mode, security_sector_mapped, sector_erase_only, security_sector_write_ok}, 4'hF);
      sx(16'h0500, 16);
      chk(rx[7:0], 8'h00);
      sx(8'h06, 8);
      sx(16'h0155, 16);
      chk({otp_lock_bit, array_write_ok, security_sector_write_ok}, 3'b100);
      sx(8'h06, 8);
      sx(8'hC7, 8);
      chk(write_in_progress, 1'b0);
      sx(8'h04, 8);
      chk(otp_mode, 1'b0);
      stop_test();
   end
endmodule // tb
`default_nettype wire
